// ---- rtl/capture_map.svh ----
`ifndef CAPTURE_MAP_SVH
`define CAPTURE_MAP_SVH

// ======================================
// Register offsets
`define OFS_CONTROL    4'h0
`define OFS_BUFFER     4'h4

// ======================================
// Control word field positions
`define BIT_IDLE_STOP  13
`define BIT_TIME_BASE  7
`define POS_THRESHOLD  5
`define BIT_OVERFLOW   4
`define BIT_NOT_EMPTY  3
`define POS_MODE       0

// ======================================
// Reset values and answers
`define CONTROL_RESET  16'h0000
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

// ======================================
// Prescaler terminal counts
`define DIV4_LAST      4'h3
`define DIV16_LAST     4'hF

`endif

// ---- rtl/capture_pkg.sv ----
package capture_pkg;

    typedef enum logic [2:0] {
        MODE_OFF   = 3'h0,
        MODE_EVERY = 3'h1,
        MODE_FALL  = 3'h2,
        MODE_RISE  = 3'h3,
        MODE_DIV4  = 3'h4,
        MODE_DIV16 = 3'h5,
        MODE_RSV6  = 3'h6,
        MODE_RSV7  = 3'h7
    } mode_t;

    typedef struct packed {
        logic       idle_stop_select;
        logic       time_base_select;
        logic [1:0] interrupt_threshold;
        mode_t      capture_mode_select;
    } ctrl_t;

endpackage

// ---- rtl/capture_edge_detect.sv ----
`timescale 1ns/1ps
`include "capture_map.svh"

module capture_edge_detect (
    // Clock and reset
    input  wire logic           i_ref_clk,
    input  wire logic           i_resetn,
    // Pin and mode
    input  wire logic           i_pin,
    input  capture_pkg::mode_t  i_mode,
    // Qualified event
    output logic                o_event
);

    logic [2:0] sync_ff;
    logic       level_ff;
    logic [3:0] pre_ff;
    logic [3:0] nxt_pre;
    logic       change;
    logic       rise;
    logic       fall;
    logic       div_mode;
    logic [3:0] pre_last;
    logic       pre_hit;

    // ======================================
    // Synchroniser and edge qualification
    assign change   = (sync_ff[1] == sync_ff[2]) && (sync_ff[2] != level_ff);
    assign rise     = change && sync_ff[2];
    assign fall     = change && !sync_ff[2];

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sync_ff  <= 3'h0;
            level_ff <= 1'b0;
        end else begin
            sync_ff  <= {sync_ff[1:0], i_pin};
            level_ff <= change ? sync_ff[2] : level_ff;
        end
    end

    // ======================================
    // Rising edge prescaler
    assign div_mode = (i_mode == capture_pkg::MODE_DIV4) || (i_mode == capture_pkg::MODE_DIV16);
    assign pre_last = (i_mode == capture_pkg::MODE_DIV4) ? `DIV4_LAST : `DIV16_LAST;
    assign pre_hit  = rise && (pre_ff == pre_last);
    assign nxt_pre  = !div_mode ? 4'h0 : (pre_hit ? 4'h0 : (rise ? pre_ff + 4'h1 : pre_ff));

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pre_ff <= 4'h0;
        end else begin
            pre_ff <= nxt_pre;
        end
    end

    // ======================================
    // Event selection
    always_comb begin
        case (i_mode)
            capture_pkg::MODE_FALL:  o_event = fall;
            capture_pkg::MODE_RISE:  o_event = rise;
            capture_pkg::MODE_EVERY: o_event = change;
            capture_pkg::MODE_DIV4:  o_event = pre_hit;
            capture_pkg::MODE_DIV16: o_event = pre_hit;
            default:                 o_event = 1'b0;
        endcase
    end

    // ======================================
    // Checks
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);

    a_fall_only: assert property ((i_mode == capture_pkg::MODE_FALL && o_event) |-> fall)
        else $error("Fall mode event without falling edge");
    a_rise_only: assert property ((i_mode == capture_pkg::MODE_RISE && o_event) |-> rise)
        else $error("Rise mode event without rising edge");
    a_div4_count: assert property ((i_mode == capture_pkg::MODE_DIV4 && o_event) |-> pre_ff == 4'h3)
        else $error("Div4 event not on fourth rising edge");
    a_div16_count: assert property ((i_mode == capture_pkg::MODE_DIV16 && o_event) |-> pre_ff == 4'hF)
        else $error("Div16 event not on sixteenth rising edge");

endmodule

// ---- rtl/input_capture_channel.sv ----
`timescale 1ns/1ps
`include "capture_map.svh"

module input_capture_channel #(
    parameter int CHANNEL = 0,
    parameter int DEPTH   = 4,
    parameter int TW      = 16
) (
    // Clock and reset
    input  wire logic          i_ref_clk,
    input  wire logic          i_resetn,
    // AXI4-Lite write address
    input  wire logic          i_awvalid,
    input  wire logic [3:0]    i_awaddr,
    output logic               o_awready,
    // AXI4-Lite write data
    input  wire logic          i_wvalid,
    input  wire logic [31:0]   i_wdata,
    input  wire logic [3:0]    i_wstrb,
    output logic               o_wready,
    // AXI4-Lite write response
    output logic               o_bvalid,
    output logic [1:0]         o_bresp,
    input  wire logic          i_bready,
    // AXI4-Lite read address
    input  wire logic          i_arvalid,
    input  wire logic [3:0]    i_araddr,
    output logic               o_arready,
    // AXI4-Lite read data
    output logic               o_rvalid,
    output logic [31:0]        o_rdata,
    output logic [1:0]         o_rresp,
    input  wire logic          i_rready,
    // Capture side
    input  wire logic          i_capture_pin,
    input  wire logic [TW-1:0] i_time_base_a,
    input  wire logic [TW-1:0] i_time_base_b,
    input  wire logic          i_idle_mode,
    input  wire logic          i_sleep_mode,
    // Requests
    output logic               o_irq,
    output logic               o_wake,
    output logic               o_dma_req
);

    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam bit HAS_DMA = (CHANNEL < 2);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

    // ======================================
    // Helpers
    function automatic logic [15:0] ctrl_word(capture_pkg::ctrl_t c, logic ovf, logic bne);
        logic [15:0] w;
        w = `CONTROL_RESET;
        w[`BIT_IDLE_STOP] = c.idle_stop_select;
        w[`BIT_TIME_BASE] = c.time_base_select;
        w[`POS_THRESHOLD +: 2] = c.interrupt_threshold;
        w[`BIT_OVERFLOW] = ovf;
        w[`BIT_NOT_EMPTY] = bne;
        w[`POS_MODE +: 3] = c.capture_mode_select;
        return w;
    endfunction

    function automatic logic [PW-1:0] ptr_inc(logic [PW-1:0] p);
        return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction

    // ======================================
    // State
    capture_pkg::ctrl_t ctrl_ff;
    capture_pkg::ctrl_t nxt_ctrl;
    logic               ovf_ff;
    logic               nxt_ovf;
    logic [TW-1:0]      fifo_ff [DEPTH];
    logic [PW-1:0]      wptr_ff;
    logic [PW-1:0]      rptr_ff;
    logic [CW-1:0]      cnt_ff;
    logic [CW-1:0]      nxt_cnt;
    logic               irq_ff;
    logic               wake_ff;
    logic               dma_ff;
    logic               aw_hold_ff;
    logic [3:0]         awaddr_ff;
    logic               w_hold_ff;
    logic [31:0]        wdata_ff;
    logic [3:0]         wstrb_ff;
    logic               awready_ff;
    logic               wready_ff;
    logic               bvalid_ff;
    logic [1:0]         bresp_ff;
    logic               arready_ff;
    logic               rvalid_ff;
    logic [31:0]        rdata_ff;
    logic [1:0]         rresp_ff;

    // ======================================
    // Bus decode
    logic          aw_hs;
    logic          w_hs;
    logic          ar_hs;
    logic          do_write;
    logic          wr_ctrl;
    logic          rd_ctrl;
    logic          rd_buf;
    logic          nxt_aw_hold;
    logic          nxt_w_hold;
    logic          nxt_bvalid;
    logic          nxt_rvalid;
    logic [15:0]   cur_word;
    logic [15:0]   merged;
    logic [31:0]   nxt_rdata;

    assign aw_hs       = i_awvalid && awready_ff;
    assign w_hs        = i_wvalid && wready_ff;
    assign ar_hs       = i_arvalid && arready_ff;
    assign do_write    = aw_hold_ff && w_hold_ff && !bvalid_ff;
    assign wr_ctrl     = do_write && (awaddr_ff == `OFS_CONTROL);
    assign rd_ctrl     = ar_hs && (i_araddr == `OFS_CONTROL);
    assign rd_buf      = ar_hs && (i_araddr == `OFS_BUFFER);
    assign nxt_aw_hold = (aw_hold_ff && !do_write) || aw_hs;
    assign nxt_w_hold  = (w_hold_ff && !do_write) || w_hs;
    assign nxt_bvalid  = do_write || (bvalid_ff && !i_bready);
    assign nxt_rvalid  = ar_hs || (rvalid_ff && !i_rready);
    assign cur_word    = ctrl_word(ctrl_ff, ovf_ff, cnt_ff != '0);
    assign merged      = {wstrb_ff[1] ? wdata_ff[15:8] : cur_word[15:8],
                          wstrb_ff[0] ? wdata_ff[7:0] : cur_word[7:0]};

    assign nxt_ctrl = wr_ctrl ? capture_pkg::ctrl_t'{idle_stop_select:    merged[`BIT_IDLE_STOP],
                                  time_base_select:    merged[`BIT_TIME_BASE],
                                  interrupt_threshold: merged[`POS_THRESHOLD +: 2],
                                  capture_mode_select: capture_pkg::mode_t'(merged[2:0])}
                              : ctrl_ff;

    // ======================================
    // Capture path
    logic          ev;
    logic          run;
    logic          cap_ev;
    logic          pop;
    logic          push;
    logic          ovf_set;
    logic [TW-1:0] sel_time;

    capture_edge_detect u_edge (
        .i_ref_clk (i_ref_clk),
        .i_resetn  (i_resetn),
        .i_pin     (i_capture_pin),
        .i_mode    (ctrl_ff.capture_mode_select),
        .o_event   (ev)
    );

    assign run      = !(ctrl_ff.idle_stop_select && i_idle_mode);
    assign cap_ev   = ev && run;
    assign pop      = rd_buf && (cnt_ff != '0);
    assign push     = cap_ev && ((cnt_ff != FULL_CNT) || pop);
    assign ovf_set  = cap_ev && !push;
    assign sel_time = ctrl_ff.time_base_select ? i_time_base_b : i_time_base_a;
    assign nxt_cnt  = cnt_ff + CW'(push) - CW'(pop);
    assign nxt_ovf  = ovf_set ||
                      (ovf_ff && !(wr_ctrl && nxt_ctrl.capture_mode_select == capture_pkg::MODE_OFF));
    assign nxt_rdata = rd_ctrl ? {16'h0000, cur_word} :
                       pop     ? {{(32 - TW){1'b0}}, fifo_ff[rptr_ff]} : 32'h0000_0000;

    // ======================================
    // Registers
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ctrl_ff <= '0;
            ovf_ff  <= 1'b0;
            wptr_ff <= '0;
            rptr_ff <= '0;
            cnt_ff  <= '0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            ovf_ff  <= nxt_ovf;
            wptr_ff <= push ? ptr_inc(wptr_ff) : wptr_ff;
            rptr_ff <= pop ? ptr_inc(rptr_ff) : rptr_ff;
            cnt_ff  <= nxt_cnt;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (push) begin
            fifo_ff[wptr_ff] <= sel_time;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            irq_ff  <= 1'b0;
            wake_ff <= 1'b0;
            dma_ff  <= 1'b0;
        end else begin
            irq_ff  <= push && (nxt_cnt == CW'(ctrl_ff.interrupt_threshold) + CW'(1));
            wake_ff <= ev && (i_sleep_mode || i_idle_mode);
            dma_ff  <= HAS_DMA && push;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            aw_hold_ff <= 1'b0;
            w_hold_ff  <= 1'b0;
            awaddr_ff  <= 4'h0;
            wdata_ff   <= 32'h0000_0000;
            wstrb_ff   <= 4'h0;
            awready_ff <= 1'b1;
            wready_ff  <= 1'b1;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= `RESP_OKAY;
        end else begin
            aw_hold_ff <= nxt_aw_hold;
            w_hold_ff  <= nxt_w_hold;
            awaddr_ff  <= aw_hs ? i_awaddr : awaddr_ff;
            wdata_ff   <= w_hs ? i_wdata : wdata_ff;
            wstrb_ff   <= w_hs ? i_wstrb : wstrb_ff;
            awready_ff <= !nxt_aw_hold && !nxt_bvalid;
            wready_ff  <= !nxt_w_hold && !nxt_bvalid;
            bvalid_ff  <= nxt_bvalid;
            bresp_ff   <= do_write ? (wr_ctrl ? `RESP_OKAY : `RESP_SLVERR) : bresp_ff;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            arready_ff <= 1'b1;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h0000_0000;
            rresp_ff   <= `RESP_OKAY;
        end else begin
            arready_ff <= !nxt_rvalid;
            rvalid_ff  <= nxt_rvalid;
            rdata_ff   <= ar_hs ? nxt_rdata : rdata_ff;
            rresp_ff   <= ar_hs ? ((rd_ctrl || rd_buf) ? `RESP_OKAY : `RESP_SLVERR) : rresp_ff;
        end
    end

    // ======================================
    // Outputs
    assign o_awready = awready_ff;
    assign o_wready  = wready_ff;
    assign o_bvalid  = bvalid_ff;
    assign o_bresp   = bresp_ff;
    assign o_arready = arready_ff;
    assign o_rvalid  = rvalid_ff;
    assign o_rdata   = rdata_ff;
    assign o_rresp   = rresp_ff;
    assign o_irq     = irq_ff;
    assign o_wake    = wake_ff;
    assign o_dma_req = dma_ff;

    // ======================================
    // Checks
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);

    a_fifo_bound: assert property (cnt_ff <= FULL_CNT)
        else $error("FIFO count above depth");
    a_capture_value: assert property (push |=> fifo_ff[$past(wptr_ff)] == $past(sel_time))
        else $error("Captured value differs from timer");
    a_base_select: assert property ($past(ctrl_ff.time_base_select) && $past(push)
                                   |-> fifo_ff[$past(wptr_ff)] == $past(i_time_base_b))
        else $error("Wrong time base captured");
    a_full_keeps: assert property ((cap_ev && cnt_ff == FULL_CNT && !pop)
                                   |=> ovf_ff && cnt_ff == FULL_CNT && $stable(wptr_ff))
        else $error("Overflow not flagged or data overwritten");
    a_empty_flag: assert property ((pop && cnt_ff == CW'(1) && !push)
                                   |=> !cur_word[`BIT_NOT_EMPTY])
        else $error("Not-empty flag kept after last read");
    a_irq_level: assert property (irq_ff |-> $past(push)
                                  && cnt_ff == CW'($past(ctrl_ff.interrupt_threshold)) + CW'(1))
        else $error("Interrupt at wrong fill level");
    a_dma_gate: assert property (dma_ff |-> HAS_DMA && $past(push))
        else $error("DMA request on channel without DMA");
    a_wake_cause: assert property (wake_ff |-> $past(ev) && $past(i_sleep_mode || i_idle_mode))
        else $error("Wake without event in low power");
    a_idle_stop: assert property ((ctrl_ff.idle_stop_select && i_idle_mode) |=> $stable(cnt_ff)
                                  || $past(pop))
        else $error("Capture during idle with idle stop");
    a_bvalid_hold: assert property ((bvalid_ff && !i_bready) |=> bvalid_ff && $stable(bresp_ff))
        else $error("Write response dropped early");

    c_overflow: cover property (ovf_set);
    c_irq_four: cover property (irq_ff && ctrl_ff.interrupt_threshold == 2'h3);
    c_wake:     cover property (wake_ff);
    c_pop_push: cover property (push && pop);

endmodule

// ---- tb/capture_pin_model.sv ----
`timescale 1ns/1ps

// ======================================
// Capture source: flips the pin on request
module capture_pin_model (
    // Clock and reset
    input  wire logic i_ref_clk,
    input  wire logic i_resetn,
    // Request
    input  wire logic i_toggle,
    // Pin
    output logic      o_pin
);
    // Levels last at least 2 cycles, because requests come 8 cycles apart
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_pin <= 1'b0;
        end else if (i_toggle) begin
            o_pin <= ~o_pin;
        end
    end
endmodule

// ---- tb/input_capture_channel_tb_top.sv ----
`timescale 1ns/1ps
`include "capture_map.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end

module input_capture_channel_tb_top;
    logic        clk = 0, resetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
    logic        rready = 0, pin, toggle = 0, idle = 0, sleep = 0;
    logic [3:0]  awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic [15:0] ta = 0, tb = 0;
    logic [1:0]  bresp, rresp;
    logic        awready, wready, bvalid, arvalid_ok, rvalid, irq, wake, dma, irq2, dma2;
    logic [33:0] rq[$], rexp;
    logic [1:0]  wq[$], wexp;
    int          n_errors = 0, checks_done = 0, cyc = 0, seed = 32'h5cb8;
    int          n_irq = 0, n_dma = 0, n_wake = 0, e_irq = 0, e_dma = 0, e_wake = 0;
    int          n_irq2 = 0, n_dma2 = 0;

    // ======================================
    // Clock, device, far side
    initial begin
        forever #4 clk = ~clk;
    end
    input_capture_channel #(.CHANNEL(0), .DEPTH(4), .TW(16)) i_dut (
        .i_ref_clk(clk), .i_resetn(resetn), .i_awvalid(awvalid), .i_awaddr(awaddr),
        .o_awready(awready), .i_wvalid(wvalid), .i_wdata(wdata), .i_wstrb(4'hF),
        .o_wready(wready), .o_bvalid(bvalid), .o_bresp(bresp), .i_bready(bready),
        .i_arvalid(arvalid), .i_araddr(araddr), .o_arready(arvalid_ok), .o_rvalid(rvalid),
        .o_rdata(rdata), .o_rresp(rresp), .i_rready(rready), .i_capture_pin(pin),
        .i_time_base_a(ta), .i_time_base_b(tb), .i_idle_mode(idle), .i_sleep_mode(sleep),
        .o_irq(irq), .o_wake(wake), .o_dma_req(dma));
    // Third channel: same captures, no DMA path
    input_capture_channel #(.CHANNEL(2), .DEPTH(4), .TW(16)) i_dut_nodma (
        .i_ref_clk(clk), .i_resetn(resetn), .i_awvalid(awvalid), .i_awaddr(awaddr),
        .o_awready(), .i_wvalid(wvalid), .i_wdata(wdata), .i_wstrb(4'hF),
        .o_wready(), .o_bvalid(), .o_bresp(), .i_bready(bready),
        .i_arvalid(arvalid), .i_araddr(araddr), .o_arready(), .o_rvalid(),
        .o_rdata(), .o_rresp(), .i_rready(rready), .i_capture_pin(pin),
        .i_time_base_a(ta), .i_time_base_b(tb), .i_idle_mode(idle), .i_sleep_mode(sleep),
        .o_irq(irq2), .o_wake(), .o_dma_req(dma2));
    capture_pin_model i_pin (.i_ref_clk(clk), .i_resetn(resetn), .i_toggle(toggle),
        .o_pin(pin));

    // ======================================
    // Monitor: answers against oldest note
    always @(posedge clk) begin
        cyc++;
        if (rvalid === 1'b1 && rready) begin
            rexp = rq.pop_front();
            `CHK({rresp, rdata}, rexp)
        end
        if (bvalid === 1'b1 && bready) begin
            wexp = wq.pop_front();
            `CHK(bresp, wexp)
        end
        if (irq === 1'b1) n_irq++;
        if (dma === 1'b1) n_dma++;
        if (wake === 1'b1) n_wake++;
        if (irq2 === 1'b1) n_irq2++;
        if (dma2 === 1'b1) n_dma2++;
        if (cyc == 20000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    // ======================================
    // Bus tasks
    task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        wq.push_back(r);
        @(posedge clk);
        awvalid <= 1; awaddr <= a; wvalid <= 1; wdata <= d; bready <= 1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (bvalid !== 1'b1);
        bready <= 0;
    endtask

    task automatic axi_read(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        rq.push_back({r, d});
        @(posedge clk);
        arvalid <= 1; araddr <= a; rready <= 1;
        do begin
            @(posedge clk);
            if (arvalid_ok) arvalid <= 0;
        end while (rvalid !== 1'b1);
        rready <= 0;
    endtask

    function automatic bit hit(capture_pkg::mode_t m, int k);
        case (m)
            capture_pkg::MODE_FALL:  return k % 2 == 0;
            capture_pkg::MODE_RISE:  return k % 2 == 1;
            capture_pkg::MODE_EVERY: return 1;
            capture_pkg::MODE_DIV4:  return k % 2 == 1 && ((k + 1) / 2) % 4 == 0;
            capture_pkg::MODE_DIV16: return k % 2 == 1 && ((k + 1) / 2) % 16 == 0;
            default:                 return 0;
        endcase
    endfunction

    // ======================================
    // One capture case: program, pulse pin, drain
    task automatic run_case(input capture_pkg::mode_t m, input int n, input logic [1:0] thr,
                            input logic stp, input logic idl, input logic slp);
        logic [15:0] vals[$];
        logic [15:0] va, vb;
        logic        sel;
        logic [31:0] ctl, st;
        int          hits;
        sel = $random(seed);
        hits = 0;
        ctl = {18'h0, stp, 5'h0, sel, thr, 2'h0, 3'(m)};
        idle <= idl;
        sleep <= slp;
        axi_write(`OFS_CONTROL, ctl, `RESP_OKAY);
        for (int k = 1; k <= n; k++) begin
            va = $random(seed);
            vb = $random(seed);
            ta <= va; tb <= vb; toggle <= 1;
            @(posedge clk);
            toggle <= 0;
            repeat (7) @(posedge clk);
            if (hit(m, k)) begin
                if (idl || slp) e_wake++;
                if (!(idl && stp)) begin
                    hits++;
                    if (vals.size() < 4) vals.push_back(sel ? vb : va);
                end
            end
        end
        e_irq += (vals.size() >= thr + 1);
        e_dma += vals.size();
        st = ctl | (32'(hits > 4) << `BIT_OVERFLOW);
        axi_read(`OFS_CONTROL, st | (32'(vals.size() > 0) << `BIT_NOT_EMPTY), `RESP_OKAY);
        foreach (vals[i]) axi_read(`OFS_BUFFER, {16'h0, vals[i]}, `RESP_OKAY);
        axi_read(`OFS_CONTROL, st, `RESP_OKAY);
        axi_write(`OFS_CONTROL, 32'h0, `RESP_OKAY);
        idle <= 0;
        sleep <= 0;
    endtask

    task automatic tally_and_finish();
        if (n_errors == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ======================================
    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        resetn <= 1;
        axi_read(`OFS_CONTROL, {16'h0, `CONTROL_RESET}, `RESP_OKAY);
        axi_read(4'h8, 32'h0, `RESP_SLVERR);
        axi_write(`OFS_BUFFER, 32'h1234, `RESP_SLVERR);
        axi_read(`OFS_BUFFER, 32'h0, `RESP_OKAY);
        run_case(capture_pkg::MODE_FALL, 4, 2'h0, 0, 0, 0);
        run_case(capture_pkg::MODE_RISE, 4, 2'h0, 0, 0, 0);
        run_case(capture_pkg::MODE_EVERY, 4, 2'h0, 0, 0, 0);
        run_case(capture_pkg::MODE_DIV4, 16, 2'h0, 0, 0, 0);
        run_case(capture_pkg::MODE_DIV16, 32, 2'h0, 0, 0, 0);
        run_case(capture_pkg::MODE_OFF, 4, 2'h0, 0, 0, 0);
        run_case(capture_pkg::MODE_RSV6, 4, 2'h0, 0, 0, 0);
        run_case(capture_pkg::MODE_EVERY, 6, 2'h3, 0, 0, 0);
        run_case(capture_pkg::MODE_EVERY, 4, 2'h2, 0, 0, 0);
        run_case(capture_pkg::MODE_RISE, 4, 2'h0, 1, 1, 0);
        run_case(capture_pkg::MODE_RISE, 4, 2'h1, 0, 1, 0);
        run_case(capture_pkg::MODE_EVERY, 2, 2'h1, 0, 0, 1);
        repeat (4) @(posedge clk);
        `CHK(n_irq, e_irq)
        `CHK(n_dma, e_dma)
        `CHK(n_wake, e_wake)
        `CHK(n_irq2, e_irq)
        `CHK(n_dma2, 0)
        tally_and_finish();
    end
endmodule
